// File: rtl/dmr_mode_regs.sv
// Mode-register logic: latency, self-refresh rate, termination, pattern.
`timescale 1ns/10ps
// Overview of operation
// - Additive latency field picks zero, read-1, read-2
// - Second register holds value until rewritten
// - Second register bits five-three set write latency
// - Total write latency is column plus additive
// - Auto rate doubles self refresh when hot
// - Forced bit always doubles; both clear single
// - Nonzero write termination field enables dynamic
// - Write termination during burst, then nominal
// - Write termination works without nominal termination
// - No dynamic termination during write leveling
// - Third register bit two redirects reads
// - Mode bits ignored while redirection disabled
// - Redirected reads use normal read latency
// - Reset honoured while redirection is enabled
// - Calibration data readable by repeated reads
// - Predefined pattern alternates zero, one, LSB first
// - Bank address 010/011 selects second/third register
module dmr_mode_regs
    import dmr_pkg::*;
(
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    input  dmr_pkg::dmr_cmd_t     cmd_i,
    input  wire logic [4:0]       column_read_latency_i,
    input  wire logic [2:0]       nominal_termination_i,
    input  wire logic             write_leveling_i,
    input  wire logic             odt_i,
    input  wire logic             case_hot_i,
    output logic [4:0]            posted_additive_latency_o,
    output logic [4:0]            total_write_latency_o,
    output logic [4:0]            read_latency_o,
    output logic [18:0]           second_extended_mode_reg_o,
    output logic [18:0]           third_extended_mode_reg_o,
    output logic                  write_burst_o,
    output dmr_pkg::dmr_term_t    term_sel_o,
    output logic [1:0]            write_termination_o,
    output logic                  selfrefresh_double_rate_o,
    output logic                  cal_enable_o,
    output logic                  read_from_cal_o,
    output logic                  rd_valid_o,
    output logic                  rd_data_o,
    output logic                  cmd_violation_o,
    output logic                  rate_conflict_o
);
    import dmr_pkg::*;
    `include "dmr_regs.svh"

    // ---------------------------------------------------------------
    // Command decode
    // ---------------------------------------------------------------
    logic        is_mrs;
    logic        is_read;
    logic        is_write;
    logic [18:0] mrs_value;

    assign is_mrs    = cmd_i.valid && (cmd_i.op == DMR_OP_MRS);
    assign is_read   = cmd_i.valid && ((cmd_i.op == DMR_OP_READ) ||
                                       (cmd_i.op == DMR_OP_READ_AP));
    assign is_write  = cmd_i.valid && (cmd_i.op == DMR_OP_WRITE);
    assign mrs_value = {cmd_i.ba, cmd_i.addr};

    // ---------------------------------------------------------------
    // Stored mode fields
    // ---------------------------------------------------------------
    logic [1:0]  add_lat_sel_q;
    logic [18:0] second_mode_q;
    logic [18:0] third_mode_q;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            add_lat_sel_q <= `DMR_ADD_LAT_RESET;
        else if (is_mrs && cmd_i.ba == `DMR_SEL_FIRST)
            add_lat_sel_q <= cmd_i.addr[`DMR_ADD_LAT_LSB +: 2];
    end

    // The stored value only changes on a write that addresses it.
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            second_mode_q <= `DMR_MR_RESET;
        else if (is_mrs && cmd_i.ba == `DMR_SEL_SECOND)
            second_mode_q <= mrs_value;
    end

    // Reset clears the redirection even while it is enabled.
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            third_mode_q <= `DMR_MR_RESET;
        else if (is_mrs && cmd_i.ba == `DMR_SEL_THIRD)
            third_mode_q <= mrs_value;
    end

    // ---------------------------------------------------------------
    // Field extraction
    // ---------------------------------------------------------------
    logic       auto_rate_en;
    logic       forced_rate_en;
    logic [1:0] write_termination;
    logic       cal_en;
    logic [1:0] cal_mode;
    logic [4:0] add_lat_cycles;
    logic [4:0] col_wr_cycles;
    logic [4:0] wr_lat_cycles;
    logic [4:0] rl_cycles;

    assign auto_rate_en   = second_mode_q[`DMR_AUTO_RATE_BIT];
    assign forced_rate_en = second_mode_q[`DMR_FORCE_RATE_BIT];
    assign write_termination = second_mode_q[`DMR_RTTWR_LSB +: 2];
    assign cal_en = third_mode_q[`DMR_CAL_EN_BIT];

    // Mode bits are forced to the predefined pattern when disabled.
    assign cal_mode = cal_en ? third_mode_q[`DMR_CAL_MODE_LSB +: 2]
                             : `DMR_CAL_PREDEF;

    always_comb
    begin
        case (add_lat_sel_q)
            `DMR_ADD_LAT_RD_M1: add_lat_cycles = column_read_latency_i - 5'h01;
            `DMR_ADD_LAT_RD_M2: add_lat_cycles = column_read_latency_i - 5'h02;
            default:            add_lat_cycles = 5'h00;
        endcase
    end

    assign col_wr_cycles = `DMR_COL_WR_BASE +
                        {2'h0, second_mode_q[`DMR_COL_WR_LSB +: 3]};
    assign wr_lat_cycles = col_wr_cycles + add_lat_cycles;
    assign rl_cycles     = column_read_latency_i + add_lat_cycles;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            posted_additive_latency_o <= 5'h00;
            total_write_latency_o     <= `DMR_COL_WR_BASE;
            read_latency_o            <= 5'h00;
        end
        else
        begin
            posted_additive_latency_o <= add_lat_cycles;
            total_write_latency_o     <= wr_lat_cycles;
            read_latency_o            <= rl_cycles;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            second_extended_mode_reg_o <= `DMR_MR_RESET;
            third_extended_mode_reg_o  <= `DMR_MR_RESET;
        end
        else
        begin
            second_extended_mode_reg_o <= second_mode_q;
            third_extended_mode_reg_o  <= third_mode_q;
        end
    end

    // ---------------------------------------------------------------
    // Self-refresh rate
    // ---------------------------------------------------------------
    logic hot_meta_q;
    logic hot_sync_q;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            hot_meta_q <= 1'b0;
            hot_sync_q <= 1'b0;
        end
        else
        begin
            hot_meta_q <= case_hot_i;
            hot_sync_q <= hot_meta_q;
        end
    end

    // The sensor may flag hot somewhat below the nominal threshold.
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            selfrefresh_double_rate_o <= 1'b0;
            rate_conflict_o           <= 1'b0;
        end
        else
        begin
            selfrefresh_double_rate_o <= forced_rate_en
                                   || (auto_rate_en && hot_sync_q);
            rate_conflict_o <= auto_rate_en && forced_rate_en;
        end
    end

    // ---------------------------------------------------------------
    // Write bursts and termination
    // ---------------------------------------------------------------
    dmr_beat_t wr_beat;
    dmr_term_t term_d;
    logic      dyn_term_en;

    dmr_burst_timer u_wr_timer (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .start_i    (is_write),
        .chop_i     (cmd_i.addr[`DMR_CHOP_BIT]),
        .nibble_i   (1'b0),
        .latency_i  (wr_lat_cycles),
        .beat_o     (wr_beat)
    );

    assign dyn_term_en = (write_termination != 2'h0)
                      && !write_leveling_i;

    always_comb
    begin
        term_d = DMR_TERM_HIGHZ;
        if (wr_beat.valid && dyn_term_en)
            term_d = DMR_TERM_WRITE;
        else if (odt_i && nominal_termination_i != 3'h0)
            term_d = DMR_TERM_NOMINAL;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            term_sel_o          <= DMR_TERM_HIGHZ;
            write_burst_o       <= 1'b0;
            write_termination_o <= 2'h0;
        end
        else
        begin
            term_sel_o          <= term_d;
            write_burst_o       <= wr_beat.valid;
            write_termination_o <= write_termination;
        end
    end

    // ---------------------------------------------------------------
    // Calibration read redirection
    // ---------------------------------------------------------------
    dmr_beat_t rd_beat;
    logic      cal_bit;
    logic      cal_read_q;

    // Reads that start while redirection is on take calibration data.
    dmr_burst_timer u_rd_timer (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .start_i    (is_read && cal_en),
        .chop_i     (cmd_i.addr[`DMR_CHOP_BIT]),
        .nibble_i   (cmd_i.addr[`DMR_NIBBLE_BIT]),
        .latency_i  (rl_cycles),
        .beat_o     (rd_beat)
    );

    dmr_pattern_gen u_pattern (
        .beat_i (rd_beat),
        .mode_i (cal_mode),
        .bit_o  (cal_bit)
    );

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            cal_read_q <= 1'b0;
        else if (is_read)
            cal_read_q <= cal_en;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            cal_enable_o    <= 1'b0;
            read_from_cal_o <= 1'b0;
            rd_valid_o      <= 1'b0;
            rd_data_o       <= 1'b0;
        end
        else
        begin
            cal_enable_o    <= cal_en;
            read_from_cal_o <= cal_read_q;
            rd_valid_o      <= rd_beat.valid;
            rd_data_o       <= rd_beat.valid && cal_bit;
        end
    end

    // ---------------------------------------------------------------
    // Command checking while redirection is enabled
    // ---------------------------------------------------------------
    logic bad_cmd;

    // Only reads, NOPs and a write to the third register are legal then.
    assign bad_cmd = cal_en && cmd_i.valid
                  && (cmd_i.op != DMR_OP_NOP) && !is_read
                  && !(is_mrs && cmd_i.ba == `DMR_SEL_THIRD);

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            cmd_violation_o <= 1'b0;
        else
            cmd_violation_o <= bad_cmd;
    end

endmodule // dmr_mode_regs

// File: rtl/dmr_regs.svh
// Offsets, field positions, reset values and counts of the mode registers.
`ifndef DMR_REGS_SVH
`define DMR_REGS_SVH

// ---------------------------------------------------------------
// Register selection on the bank-address inputs
// ---------------------------------------------------------------
`define DMR_SEL_FIRST     3'h1
`define DMR_SEL_SECOND    3'h2
`define DMR_SEL_THIRD     3'h3

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define DMR_ADD_LAT_LSB   3
`define DMR_COL_WR_LSB    3
`define DMR_AUTO_RATE_BIT 6
`define DMR_FORCE_RATE_BIT 7
`define DMR_RTTWR_LSB     9
`define DMR_CAL_EN_BIT    2
`define DMR_CAL_MODE_LSB  0
`define DMR_CHOP_BIT      12
`define DMR_NIBBLE_BIT    2

// ---------------------------------------------------------------
// Field encodings and reset values
// ---------------------------------------------------------------
`define DMR_ADD_LAT_ZERO  2'h0
`define DMR_ADD_LAT_RD_M1 2'h1
`define DMR_ADD_LAT_RD_M2 2'h2
`define DMR_CAL_PREDEF    2'h0
`define DMR_MR_RESET      19'h00000
`define DMR_ADD_LAT_RESET 2'h0

// ---------------------------------------------------------------
// Timing counts in clock cycles
// ---------------------------------------------------------------
`define DMR_COL_WR_BASE   5'h05
`define DMR_BEATS_BL8     4'h8
`define DMR_BEATS_BC4     4'h4

`endif

// File: rtl/dmr_pkg.sv
// Types shared by the mode-register block and its helpers.
package dmr_pkg;

    typedef enum logic [2:0] {
        DMR_OP_NOP,
        DMR_OP_MRS,
        DMR_OP_READ,
        DMR_OP_READ_AP,
        DMR_OP_WRITE,
        DMR_OP_OTHER
    } dmr_op_t;

    typedef struct packed {
        logic        valid;
        dmr_op_t     op;
        logic [2:0]  ba;
        logic [15:0] addr;
    } dmr_cmd_t;

    typedef enum logic [1:0] {
        DMR_TERM_HIGHZ,
        DMR_TERM_NOMINAL,
        DMR_TERM_WRITE
    } dmr_term_t;

    typedef struct packed {
        logic       valid;
        logic       chop;
        logic       nibble;
        logic [3:0] beat;
    } dmr_beat_t;

endpackage

// File: rtl/dmr_burst_timer.sv
// Delays a burst start by a programmable latency and counts its beats.
`timescale 1ns/10ps
module dmr_burst_timer
    import dmr_pkg::*;
(
    input  wire logic            core_clk_i,
    input  wire logic            rst_i,
    input  wire logic            start_i,
    input  wire logic            chop_i,
    input  wire logic            nibble_i,
    input  wire logic [4:0]      latency_i,
    output dmr_pkg::dmr_beat_t   beat_o
);
    `include "dmr_regs.svh"

    // Each stage holds valid, chop and nibble of a start in flight.
    logic [2:0] line_q [32];
    logic [2:0] tap;
    logic [3:0] left_q;

    assign tap = (latency_i == 5'h00) ? {start_i, chop_i, nibble_i}
                                      : line_q[latency_i - 5'h01];

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < 32; i++)
                line_q[i] <= 3'h0;
        end
        else
        begin
            line_q[0] <= {start_i, chop_i, nibble_i};
            for (int i = 1; i < 32; i++)
                line_q[i] <= line_q[i-1];
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            left_q <= 4'h0;
            beat_o <= '0;
        end
        else if (tap[2])
        begin
            left_q <= (tap[1] ? `DMR_BEATS_BC4 : `DMR_BEATS_BL8) - 4'h1;
            beat_o <= '{valid: 1'b1, chop: tap[1], nibble: tap[0],
                        beat: 4'h0};
        end
        else if (left_q != 4'h0)
        begin
            left_q      <= left_q - 4'h1;
            beat_o.beat <= beat_o.beat + 4'h1;
        end
        else
        begin
            beat_o.valid <= 1'b0;
        end
    end
endmodule // dmr_burst_timer

// File: rtl/dmr_pattern_gen.sv
// Returns the calibration data bit for one beat of a redirected read.
`timescale 1ns/10ps
module dmr_pattern_gen
    import dmr_pkg::*;
(
    input  dmr_pkg::dmr_beat_t beat_i,
    input  wire logic [1:0]    mode_i,
    output logic               bit_o
);
    `include "dmr_regs.svh"

    logic [2:0] order;

    // A chopped burst on the upper nibble starts at burst position 4.
    always_comb
    begin
        order = beat_i.beat[2:0];
        if (beat_i.chop && beat_i.nibble)
            order = beat_i.beat[2:0] + 3'h4;
        bit_o = 1'b0;
        if (mode_i == `DMR_CAL_PREDEF)
            bit_o = order[0];
    end
endmodule // dmr_pattern_gen

// File: testbench/dmr_mode_regs_checker.sv
// Port-level assertions for the mode-register block.
`timescale 1ns/10ps
module dmr_mode_regs_checker
    import dmr_pkg::*;
(
    input wire logic          core_clk_i,
    input wire logic          rst_i,
    input dmr_pkg::dmr_cmd_t  cmd_i,
    input wire logic [4:0]    column_read_latency_i,
    input wire logic          write_leveling_i,
    input wire logic [4:0]    posted_additive_latency_o,
    input wire logic [4:0]    total_write_latency_o,
    input wire logic [4:0]    read_latency_o,
    input wire logic [18:0]   second_extended_mode_reg_o,
    input wire logic          write_burst_o,
    input dmr_pkg::dmr_term_t term_sel_o,
    input wire logic          selfrefresh_double_rate_o,
    input wire logic          cal_enable_o,
    input wire logic          rd_valid_o,
    input wire logic          rd_data_o
);
    logic       mrs;
    logic       quiet;
    logic [1:0] quiet_q;
    logic [4:0] rd_lat_q;
    logic [5:0] cnt_q;

    assign mrs = cmd_i.valid && cmd_i.op == DMR_OP_MRS;
    assign quiet = quiet_q == 2'h3;

    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    // Settled outputs are only trusted a few cycles after any change.
    always_ff @(posedge core_clk_i)
    begin
        rd_lat_q <= column_read_latency_i;
        if (rst_i || mrs || rd_lat_q != column_read_latency_i)
            quiet_q <= 2'h0;
        else if (!quiet)
            quiet_q <= quiet_q + 2'h1;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            cnt_q <= 6'h00;
        else if (cmd_i.valid && cal_enable_o && (cmd_i.op == DMR_OP_READ ||
                 cmd_i.op == DMR_OP_READ_AP))
            cnt_q <= {1'b0, read_latency_o} + 6'h01;
        else if (cnt_q != 6'h00)
            cnt_q <= cnt_q - 6'h01;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    a_reset_values : assert property (
        $fell(rst_i) |-> total_write_latency_o == 5'h05 &&
        term_sel_o == DMR_TERM_HIGHZ && !cal_enable_o)
        else $error("outputs not at reset values");
    a_second_store : assert property (
        mrs && cmd_i.ba == 3'h2 |-> ##2
        second_extended_mode_reg_o == {3'h2, $past(cmd_i.addr, 2)})
        else $error("second register not loaded");
    a_cal_enable : assert property (
        mrs && cmd_i.ba == 3'h3 |-> ##2
        cal_enable_o == $past(cmd_i.addr[2], 2))
        else $error("calibration enable not loaded");
    a_total_latency : assert property (
        quiet |-> total_write_latency_o == 5'h05 +
        second_extended_mode_reg_o[5:3] + posted_additive_latency_o)
        else $error("write latency is not column plus additive");
    a_cal_read_time : assert property (
        cnt_q == 6'h01 |-> ##[0:2] rd_valid_o)
        else $error("redirected read data late");
    a_pattern_first : assert property (
        $rose(rd_valid_o) |-> !rd_data_o)
        else $error("calibration burst does not start with zero");
    a_forced_rate : assert property (
        quiet && !second_extended_mode_reg_o[6] |->
        selfrefresh_double_rate_o == second_extended_mode_reg_o[7])
        else $error("self refresh rate wrong");
    a_level_term : assert property (
        write_leveling_i && $past(write_leveling_i) |->
        term_sel_o != DMR_TERM_WRITE)
        else $error("write termination during leveling");
    a_write_term : assert property (
        quiet && write_burst_o && !write_leveling_i &&
        !$past(write_leveling_i) && second_extended_mode_reg_o[10:9] != 2'h0
        |-> term_sel_o == DMR_TERM_WRITE)
        else $error("write termination missing in burst");

    c_cal_read : cover property (rd_valid_o && cal_enable_o);
    c_write_term : cover property (term_sel_o == DMR_TERM_WRITE);
    c_auto_rate : cover property (selfrefresh_double_rate_o &&
                                  !second_extended_mode_reg_o[7]);
endmodule // dmr_mode_regs_checker

bind dmr_mode_regs dmr_mode_regs_checker chk_u (
    .core_clk_i, .rst_i, .cmd_i, .column_read_latency_i,
    .write_leveling_i, .posted_additive_latency_o, .total_write_latency_o,
    .read_latency_o, .second_extended_mode_reg_o, .write_burst_o,
    .term_sel_o, .selfrefresh_double_rate_o, .cal_enable_o, .rd_valid_o,
    .rd_data_o
);

// File: testbench/dmr_ctrl_model.sv
// Memory-controller model driving the command bus of the block.
`timescale 1ns/10ps
module dmr_ctrl_model
    import dmr_pkg::*;
#(
    parameter int MOD_DELAY = 4
)
(
    input  wire logic         core_clk_i,
    output dmr_pkg::dmr_cmd_t cmd_o
);
    // ------------------------------------------------------------
    // Command issue
    // ------------------------------------------------------------
    initial cmd_o = '0;

    // One command for one cycle; the idle bus then shows scrambled bits.
    task automatic send(input dmr_op_t op, input logic [2:0] ba,
                        input logic [15:0] addr);
        @(negedge core_clk_i);
        cmd_o = {1'b1, op, ba, addr};
        @(negedge core_clk_i);
        cmd_o = {1'b0, DMR_OP_NOP, ~ba, ~addr};
    endtask

    // The model never opens a row, so every bank is idle here.
    task automatic mrs(input logic [2:0] ba, input logic [15:0] addr);
        logic [15:0] a;
        a = addr;
        if (ba == 3'h2)
            a = a & 16'h06F8;
        if (ba == 3'h2 && a[7])
            a[6] = 1'b0;
        if (ba == 3'h3)
            a = a & 16'h0007;
        send(DMR_OP_MRS, ba, a);
        repeat (MOD_DELAY) @(negedge core_clk_i);
    endtask
endmodule // dmr_ctrl_model

// File: testbench/test_dram_mode_reg_two_three_mpr.sv
// Self-checking bench for the mode-register block.
`timescale 1ns/10ps
`include "dmr_regs.svh"
module test_dram_mode_reg_two_three_mpr;
    import dmr_pkg::*;
    logic        core_clk_i;
    logic        rst_i;
    dmr_cmd_t    cmd_i;
    logic [4:0]  column_read_latency_i;
    logic [2:0]  nominal_termination_i;
    logic        write_leveling_i;
    logic        odt_i;
    logic        case_hot_i;
    logic [4:0]  posted_additive_latency_o;
    logic [4:0]  total_write_latency_o;
    logic [4:0]  read_latency_o;
    logic [18:0] second_extended_mode_reg_o;
    logic [18:0] third_extended_mode_reg_o;
    logic        write_burst_o;
    dmr_term_t   term_sel_o;
    logic [1:0]  write_termination_o;
    logic        selfrefresh_double_rate_o;
    logic        cal_enable_o;
    logic        read_from_cal_o;
    logic        rd_valid_o;
    logic        rd_data_o;
    logic        cmd_violation_o;
    logic        rate_conflict_o;
    logic        rd_q[$];
    dmr_term_t   wr_q[$];
    int          n_errors;
    int          check_count;
    logic [4:0]  rd_lat;
    logic [4:0]  add_lat;
    logic [1:0]  rtt;

    dmr_ctrl_model ctrl_u (.core_clk_i, .cmd_o(cmd_i));
    dmr_mode_regs dut_u (
        .core_clk_i, .rst_i, .cmd_i, .column_read_latency_i,
        .nominal_termination_i, .write_leveling_i, .odt_i, .case_hot_i,
        .posted_additive_latency_o, .total_write_latency_o, .read_latency_o,
        .second_extended_mode_reg_o, .third_extended_mode_reg_o,
        .write_burst_o, .term_sel_o, .write_termination_o,
        .selfrefresh_double_rate_o, .cal_enable_o, .read_from_cal_o,
        .rd_valid_o, .rd_data_o, .cmd_violation_o, .rate_conflict_o
    );

    initial
    begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end

    task automatic check(input string name, input logic [18:0] seen,
                         input logic [18:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        if (n_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Result monitor and watchdog
    // ------------------------------------------------------------
    always @(negedge core_clk_i)
    begin
        if (!rst_i && rd_valid_o)
            check("rd_data", rd_data_o,
                  rd_q.size() > 0 ? rd_q.pop_front() : 1'bx);
        if (!rst_i && write_burst_o && !write_leveling_i)
            check("term_wr", term_sel_o,
                  wr_q.size() > 0 ? wr_q.pop_front() : 2'bxx);
        if (!rst_i)
            check("viol", cmd_violation_o, 1'b0);
    end

    initial
    begin
        repeat (20000) @(negedge core_clk_i);
        n_errors++;
        test_done();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        n_errors = 0;
        check_count = 0;
        rst_i = 1'b1;
        column_read_latency_i = 5'h06;
        nominal_termination_i = 3'h2;
        write_leveling_i = 1'b0;
        odt_i = 1'b1;
        case_hot_i = 1'b0;
        void'($urandom(15));
        repeat (16) @(negedge core_clk_i);
        check("wl_rst", total_write_latency_o, `DMR_COL_WR_BASE);
        check("term_rst", term_sel_o, DMR_TERM_HIGHZ);
        rst_i = 1'b0;
        @(negedge core_clk_i);
        for (int i = 0; i < 8; i++)
        begin
            rd_lat = 5'h06 + 5'($urandom_range(6));
            column_read_latency_i = rd_lat;
            ctrl_u.mrs(3'h1, 16'($urandom) & 16'hFFE7 | 16'(i % 4) << 3);
            ctrl_u.mrs(3'h2, 16'(i) << 3);
            add_lat = (i % 4 == 1) ? rd_lat - 5'h01 :
                      (i % 4 == 2) ? rd_lat - 5'h02 : 5'h00;
            check("add_lat", posted_additive_latency_o, add_lat);
            check("wr_lat", total_write_latency_o,
                  `DMR_COL_WR_BASE + 5'(i) + add_lat);
            check("rd_lat", read_latency_o, rd_lat + add_lat);
        end
        ctrl_u.mrs(3'h0, 16'($urandom));
        check("mr2", second_extended_mode_reg_o, 19'h20038);
        for (int i = 0; i < 6; i++)
        begin
            case_hot_i = i[0];
            ctrl_u.mrs(3'h2, 16'(i >> 1) << 6);
            check("rate", selfrefresh_double_rate_o,
                  i >> 1 == 2 || (i >> 1 == 1 && i[0]));
            check("rate_conf", rate_conflict_o, 1'b0);
        end
        rtt = 2'(1 + $urandom_range(2));
        ctrl_u.mrs(3'h2, 16'(rtt) << 9);
        check("wr_term", write_termination_o, rtt);
        for (int j = 0; j < 3; j++)
        begin
            nominal_termination_i = (j == 1) ? 3'h0 : 3'h2;
            write_leveling_i = (j == 2);
            repeat ((j == 0) ? 8 : (j == 1) ? 4 : 0)
                wr_q.push_back(DMR_TERM_WRITE);
            ctrl_u.send(DMR_OP_WRITE, 3'h0, (j == 1) ? 16'h1000 : 16'h0000);
            repeat (40) @(negedge core_clk_i);
            check("term_end", term_sel_o, (j == 1) ? DMR_TERM_HIGHZ :
                  DMR_TERM_NOMINAL);
            check("wr_left", wr_q.size(), 0);
        end
        write_leveling_i = 1'b0;
        ctrl_u.mrs(3'h3, 16'h0003);
        check("cal_off", cal_enable_o, 1'b0);
        ctrl_u.send(DMR_OP_READ, 3'h0, 16'h0000);
        for (int m = 0; m < 4; m++)
        begin
            ctrl_u.mrs(3'h3, 16'h0004 | 16'(m));
            check("cal_on", cal_enable_o, 1'b1);
            for (int k = 0; k < 12; k++)
                rd_q.push_back(m == 0 && k[0]);
            // Only reads and writes to the third register are issued while redirection is on.
            ctrl_u.send(DMR_OP_READ, 3'h0, 16'h0000);
            repeat (8) @(negedge core_clk_i);
            ctrl_u.send(DMR_OP_READ_AP, 3'h0, 16'h1004);
            repeat (30) @(negedge core_clk_i);
            check("rd_left", rd_q.size(), 0);
            check("from_cal", read_from_cal_o, 1'b1);
        end
        rst_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        rst_i = 1'b0;
        @(negedge core_clk_i);
        check("cal_rst", cal_enable_o, 1'b0);
        check("mr3_rst", third_extended_mode_reg_o, 19'h00000);
        ctrl_u.send(DMR_OP_READ, 3'h0, 16'h0000);
        repeat (30) @(negedge core_clk_i);
        check("from_arr", read_from_cal_o, 1'b0);
        test_done();
    end
endmodule // test_dram_mode_reg_two_three_mpr
